// ==== timer_pkg.sv ====
package timer_pkg;

  // Register byte offsets on the APB slave
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_COUNT = 12'h004;
  localparam logic [11:0] ADDR_COMPARE = 12'h008;
  localparam logic [11:0] ADDR_ASYNC = 12'h00c;

  // Control register fields
  localparam int CTRL_FORCE_BIT = 7;
  localparam int CTRL_WAVE_LO_BIT = 6;
  localparam int CTRL_COM_HI_BIT = 5;
  localparam int CTRL_COM_LO_BIT = 4;
  localparam int CTRL_WAVE_HI_BIT = 3;
  localparam int CTRL_CS_HI_BIT = 2;

  // Async status register fields
  localparam int ASYNC_EXT_BIT = 4;
  localparam int ASYNC_SEL_BIT = 3;
  localparam int BUSY_COUNT_BIT = 2;
  localparam int BUSY_COMPARE_BIT = 1;
  localparam int BUSY_CONTROL_BIT = 0;

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;

  // Counter limits
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // Waveform mode codes, high bit first
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE = 2'h1;
  localparam logic [1:0] MODE_CTC = 2'h2;
  localparam logic [1:0] MODE_FAST = 2'h3;

  // Compare output mode codes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // Source edges before an async write lands
  localparam logic [1:0] COMMIT_EDGES = 2'h2;

  // Prescaler length and tap widths per clock select code
  localparam int PRESCALE_BITS = 10;
  localparam int TAP_DIV8 = 3;
  localparam int TAP_DIV32 = 5;
  localparam int TAP_DIV64 = 6;
  localparam int TAP_DIV128 = 7;
  localparam int TAP_DIV256 = 8;
  localparam int TAP_DIV1024 = 10;

  typedef enum logic {COUNT_UP, COUNT_DOWN} count_dir_e;

endpackage : timer_pkg

// ==== pin_edge_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic rise
);
  logic stage1;
  logic stage2;
  logic stage3;

  // Only stage2 and stage3 feed the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign rise = stage2 & ~stage3;
endmodule : pin_edge_sync
`default_nettype wire

// ==== tick_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler
  import timer_pkg::*;
#(
  parameter int WIDTH = PRESCALE_BITS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src_tick,
  input wire logic [2:0] clock_select,
  output logic timer_tick
);
  logic [WIDTH-1:0] div_count;
  logic [WIDTH-1:0] tap_mask;

  // Elaboration check: the longest tap must fit in the divider
  if (WIDTH < TAP_DIV1024) begin : g_width_check
    $error("tick_prescaler: WIDTH too small");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_count <= '0;
    else if (src_tick) div_count <= div_count + 1'b1;
  end

  always_comb begin
    tap_mask = '0;
    case (clock_select)
      3'h2: tap_mask = WIDTH'((1 << TAP_DIV8) - 1);
      3'h3: tap_mask = WIDTH'((1 << TAP_DIV32) - 1);
      3'h4: tap_mask = WIDTH'((1 << TAP_DIV64) - 1);
      3'h5: tap_mask = WIDTH'((1 << TAP_DIV128) - 1);
      3'h6: tap_mask = WIDTH'((1 << TAP_DIV256) - 1);
      3'h7: tap_mask = WIDTH'((1 << TAP_DIV1024) - 1);
      default: tap_mask = '0;
    endcase
  end

  // R10: stopped, direct or divided
  assign timer_tick = (clock_select != 3'h0) && src_tick &&
                      ((div_count & tap_mask) == tap_mask);
endmodule : tick_prescaler
`default_nettype wire

// ==== timer_waveform.sv ====
// Operation
// R01: Mode field bits 6,3 select four modes
// R02: TOP is 0xFF, compare value in CTC
// R03: Compare write immediate, PWM buffered to TOP
// R04: Overflow at MAX, phase mode at BOTTOM
// R05: Nonzero output mode overrides port pin
// R06: Non-PWM output mode toggle, clear, set
// R07: Fast PWM match action, opposite at TOP
// R08: Phase PWM up/down match opposite actions
// R09: PWM compare equal TOP ignores match
// R10: Clock select stop, direct, prescaled taps
// R11: Counter register full read/write access
// R12: Counter write blocks next timer match
// R13: Compare continuously, match flags or drives
// R14: External clock enable, crystal otherwise
// R15: Software sets external enable before async
// R16: Async select picks I/O or oscillator
// R17: Async switch may corrupt timer registers
// R18: Async writes set busy until landed
// R19: Per-register temp lands after two edges
// R20: Count reads live, others read temp
// R21: Prescaler source follows async select
// R22: Async reserved bits read zero
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module timer_waveform
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_osc_input_one,
  input wire logic port_direction,
  output logic osc_run,
  output logic ext_clock_buffer_on,
  output logic compare_output_pin,
  output logic compare_output_oe,
  output logic pin_override,
  output logic overflow_flag,
  output logic compare_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] control_temp;
  logic [7:0] control_register;
  logic [7:0] counter_value;
  logic [7:0] count_temp;
  logic [7:0] compare_temp;
  logic [7:0] compare_buffer;
  logic [7:0] compare_value;
  logic ext_clock_input_enable;
  logic async_clock_select;
  logic [2:0] update_busy;
  logic [2:0] land;
  logic [2:0] start_write;
  logic force_pending;
  logic block_match;
  logic wave_out;
  count_dir_e count_dir;

  logic wr_access;
  logic rd_setup;
  logic hit_control;
  logic hit_count;
  logic hit_compare;
  logic hit_async;
  logic mapped;
  logic [31:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data captured in the setup cycle
  assign pready = 1'b1;
  assign wr_access = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit_control = (paddr == ADDR_CONTROL);
  assign hit_count = (paddr == ADDR_COUNT);
  assign hit_compare = (paddr == ADDR_COMPARE);
  assign hit_async = (paddr == ADDR_ASYNC);
  assign mapped = hit_control | hit_count | hit_compare | hit_async;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_control) begin
      // R20: control reads its temp copy
      next_rdata = {24'h00_0000, 1'b0, control_temp[6:0]};
    end else if (hit_count) begin
      // R11: live counter read
      next_rdata = {24'h00_0000, counter_value};
    end else if (hit_compare) begin
      // R20: compare reads its temp copy
      next_rdata = {24'h00_0000, compare_temp};
    end else if (hit_async) begin
      // R22: reserved bits zero
      next_rdata = {24'h00_0000, 3'h0, ext_clock_input_enable, async_clock_select,
                    update_busy};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (rd_setup) prdata <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock source and prescaler
  logic osc_rise;
  logic src_tick;
  logic timer_tick;

  pin_edge_sync osc_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(timer_osc_input_one),
    .rise(osc_rise)
  );

  // R16: I/O clock or oscillator edges
  // R21: prescaler fed from same source
  assign src_tick = async_clock_select ? osc_rise : 1'b1;

  tick_prescaler prescale (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(src_tick),
    .clock_select(control_register[CTRL_CS_HI_BIT:0]),
    .timer_tick(timer_tick)
  );

  // R14: crystal only without external clock
  assign osc_run = async_clock_select & ~ext_clock_input_enable;
  assign ext_clock_buffer_on = async_clock_select & ext_clock_input_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Async status register
  // R15: software orders these writes; both bits simply store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_clock_input_enable <= 1'b0;
      async_clock_select <= 1'b0;
    end else if (wr_access && hit_async) begin
      ext_clock_input_enable <= pwdata[ASYNC_EXT_BIT];
      async_clock_select <= pwdata[ASYNC_SEL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Update-busy tracking, one channel per destination
  logic switch_source;
  assign switch_source = wr_access && hit_async &&
                         (pwdata[ASYNC_SEL_BIT] != async_clock_select);
  assign start_write[BUSY_CONTROL_BIT] = wr_access & hit_control;
  assign start_write[BUSY_COMPARE_BIT] = wr_access & hit_compare;
  assign start_write[BUSY_COUNT_BIT] = wr_access & hit_count;

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_update
      logic [1:0] edges;
      // R19: lands on the second source edge
      assign land[ch] = async_clock_select ? (update_busy[ch] && src_tick &&
                        (edges == COMMIT_EDGES - 2'h1)) : start_write[ch];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          update_busy[ch] <= 1'b0;
          edges <= 2'h0;
        end else if (switch_source) begin
          // R17: pending transfers dropped on source change
          update_busy[ch] <= 1'b0;
          edges <= 2'h0;
        end else if (start_write[ch] && async_clock_select) begin
          // R18: busy from write until landed
          update_busy[ch] <= 1'b1;
          edges <= 2'h0;
        end else if (land[ch]) begin
          update_busy[ch] <= 1'b0;
          edges <= 2'h0;
        end else if (update_busy[ch] && src_tick) begin
          edges <= edges + 2'h1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Temp registers and destinations
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_temp <= CONTROL_RESET;
      compare_temp <= COMPARE_RESET;
      count_temp <= COUNT_RESET;
    end else begin
      if (start_write[BUSY_CONTROL_BIT]) control_temp <= pwdata[7:0];
      if (start_write[BUSY_COMPARE_BIT]) compare_temp <= pwdata[7:0];
      if (start_write[BUSY_COUNT_BIT]) count_temp <= pwdata[7:0];
    end
  end

  // Sync writes land the bus data the same edge as the temp copy
  logic [7:0] control_src;
  logic [7:0] compare_src;
  logic [7:0] count_src;
  assign control_src = async_clock_select ? control_temp : pwdata[7:0];
  assign compare_src = async_clock_select ? compare_temp : pwdata[7:0];
  assign count_src = async_clock_select ? count_temp : pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_register <= CONTROL_RESET;
      force_pending <= 1'b0;
    end else if (land[BUSY_CONTROL_BIT]) begin
      control_register <= {1'b0, control_src[6:0]};
      force_pending <= control_src[CTRL_FORCE_BIT];
    end else begin
      force_pending <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) compare_buffer <= COMPARE_RESET;
    else if (land[BUSY_COMPARE_BIT]) compare_buffer <= compare_src;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and compare
  logic [1:0] waveform_mode_field;
  logic [1:0] compare_output_mode;
  logic pwm_mode;
  logic [7:0] top_value;
  logic at_top;
  logic match_raw;
  logic match;
  logic pwm_ignore;
  logic overflow_event;

  // R01: high bit 3, low bit 6
  assign waveform_mode_field = {control_register[CTRL_WAVE_HI_BIT],
                                control_register[CTRL_WAVE_LO_BIT]};
  assign compare_output_mode = control_register[CTRL_COM_HI_BIT:CTRL_COM_LO_BIT];
  assign pwm_mode = (waveform_mode_field == MODE_PHASE) || (waveform_mode_field == MODE_FAST);

  // R02: compare value is TOP in CTC
  assign top_value = (waveform_mode_field == MODE_CTC) ? compare_value : COUNT_MAX;
  assign at_top = (counter_value == top_value);

  // R13: continuous equality check
  assign match_raw = (counter_value == compare_value);
  // R09: equal-to-TOP match ignored in PWM
  assign pwm_ignore = pwm_mode && (compare_value == COUNT_MAX) && compare_output_mode[1];
  // R12: blocked right after a counter write
  assign match = timer_tick && match_raw && !block_match && !pwm_ignore;
  // R04: MAX, or BOTTOM in phase mode
  assign overflow_event = timer_tick && ((waveform_mode_field == MODE_PHASE) ?
                          (counter_value == COUNT_BOTTOM) : (counter_value == COUNT_MAX));
  // R03: immediate, or buffered until TOP
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) compare_value <= COMPARE_RESET;
    else if (!pwm_mode || (timer_tick && at_top)) compare_value <= compare_buffer;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  logic [7:0] next_count;
  count_dir_e next_dir;

  always_comb begin
    next_count = counter_value;
    next_dir = count_dir;
    case (waveform_mode_field)
      MODE_PHASE: begin
        // Turn at either end of the slope
        if (count_dir == COUNT_UP && counter_value == COUNT_MAX) next_dir = COUNT_DOWN;
        else if (count_dir == COUNT_DOWN && counter_value == COUNT_BOTTOM) next_dir = COUNT_UP;
        next_count = (next_dir == COUNT_UP) ? counter_value + 8'h01 : counter_value - 8'h01;
      end
      MODE_CTC: begin
        // R12: blocked match keeps counting
        next_count = (at_top && !block_match) ? COUNT_BOTTOM : counter_value + 8'h01;
        next_dir = COUNT_UP;
      end
      default: begin
        next_count = counter_value + 8'h01;
        next_dir = COUNT_UP;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value <= COUNT_RESET;
      count_dir <= COUNT_UP;
    end else if (land[BUSY_COUNT_BIT]) begin
      // R11: software load wins over a tick
      counter_value <= count_src;
    end else if (timer_tick) begin
      counter_value <= next_count;
      count_dir <= next_dir;
    end
  end
  // R12: one timer tick of suppression
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) block_match <= 1'b0;
    else if (land[BUSY_COUNT_BIT]) block_match <= 1'b1;
    else if (timer_tick) block_match <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waveform output
  logic next_wave;
  logic wrap_tick;
  assign wrap_tick = timer_tick && (counter_value == COUNT_MAX);

  always_comb begin
    next_wave = wave_out;
    if (waveform_mode_field == MODE_FAST) begin
      // R07: match action, opposite at TOP
      if (wrap_tick && compare_output_mode == COM_CLEAR) next_wave = 1'b1;
      else if (wrap_tick && compare_output_mode == COM_SET) next_wave = 1'b0;
      else if (match && compare_output_mode == COM_CLEAR) next_wave = 1'b0;
      else if (match && compare_output_mode == COM_SET) next_wave = 1'b1;
    end else if (waveform_mode_field == MODE_PHASE) begin
      // R08: up match one way, down match other
      if (compare_output_mode[1] && timer_tick && at_top && pwm_ignore) begin
        // R09: TOP gives the down-count result
        next_wave = (compare_output_mode == COM_CLEAR);
      end else if (match && compare_output_mode[1]) begin
        next_wave = (count_dir == COUNT_UP) ? (compare_output_mode == COM_SET) :
                    (compare_output_mode == COM_CLEAR);
      end
    end else if (match || (force_pending && land[BUSY_CONTROL_BIT] == 1'b0)) begin
      // R06: toggle, clear or set on match
      case (compare_output_mode)
        COM_TOGGLE: next_wave = ~wave_out;
        COM_CLEAR: next_wave = 1'b0;
        COM_SET: next_wave = 1'b1;
        default: next_wave = wave_out;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wave_out <= 1'b0;
    else wave_out <= next_wave;
  end
  // R05: override on nonzero mode, driver needs direction
  assign pin_override = (compare_output_mode != COM_OFF);
  assign compare_output_oe = pin_override & port_direction;
  assign compare_output_pin = wave_out;

  ////////////////////////////////////////////////////////////////////////////
  // Event pulses to the flag register outside this block
  // R13: match raises the compare flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
      compare_flag <= 1'b0;
    end else begin
      overflow_flag <= overflow_event;
      compare_flag <= match;
    end
  end
endmodule : timer_waveform
`default_nettype wire

// ==== timer_waveform_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module timer_waveform_chk
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_osc_input_one,
  input wire logic port_direction,
  input wire logic osc_run,
  input wire logic ext_clock_buffer_on,
  input wire logic compare_output_pin,
  input wire logic compare_output_oe,
  input wire logic pin_override,
  input wire logic overflow_flag,
  input wire logic compare_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr;
  logic bad;
  assign wr = psel && penable && pwrite;
  assign bad = (paddr > ADDR_ASYNC) || (paddr[1:0] != 2'h0);
  ////////////////////////////////////////
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_read_width: assert property (prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_bad_addr: assert property (
      psel && penable && !pwrite && bad |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  chk_err_phase: assert property (pslverr |-> psel && penable && bad)
    else $error("stray pslverr");
  chk_oe_gate: assert property (
      compare_output_oe == (pin_override && port_direction))
    else $error("output enable wrong");
  chk_osc_excl: assert property (!(osc_run && ext_clock_buffer_on))
    else $error("crystal and buffer both on");
  chk_clk_src: assert property (
      wr && paddr == ADDR_ASYNC |=>
      osc_run == ($past(pwdata[ASYNC_SEL_BIT]) && !$past(pwdata[ASYNC_EXT_BIT])) &&
      ext_clock_buffer_on == ($past(pwdata[ASYNC_SEL_BIT]) && $past(pwdata[ASYNC_EXT_BIT])))
    else $error("clock source enables wrong");
  // Only in sync mode, where a control write lands at once
  chk_override_set: assert property (
      wr && paddr == ADDR_CONTROL && !osc_run && !ext_clock_buffer_on
      |=> pin_override == ($past(pwdata[5:4]) != 2'h0))
    else $error("override not from mode field");
  chk_ovf_pulse: assert property (overflow_flag |=> !overflow_flag)
    else $error("overflow pulse too long");
  chk_async_rsvd: assert property (
      psel && penable && !pwrite && paddr == ADDR_ASYNC |-> prdata[7:5] == 3'h0)
    else $error("reserved status bits set");
endmodule : timer_waveform_chk

bind timer_waveform timer_waveform_chk i_timer_waveform_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_osc_input_one(timer_osc_input_one), .port_direction(port_direction),
  .osc_run(osc_run), .ext_clock_buffer_on(ext_clock_buffer_on),
  .compare_output_pin(compare_output_pin), .compare_output_oe(compare_output_oe),
  .pin_override(pin_override), .overflow_flag(overflow_flag), .compare_flag(compare_flag)
);
`default_nettype wire

// ==== timer_waveform_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module timer_waveform_tb
  import timer_pkg::*;
();
  logic pclk, presetn, psel, penable, pwrite, port_direction, osc_on, e;
  logic timer_osc_input_one, pready, pslverr, osc_run, ext_clock_buffer_on;
  logic compare_output_pin, compare_output_oe, pin_override, overflow_flag, compare_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] c;
  logic [1:0] md, com;
  logic [2:0] osc_cnt;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int p, h, n;
  int div[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  int ovf_gap[4] = '{255, 509, 600, 255};
  logic [7:0] busy[3] = '{8'h01, 8'h04, 8'h02};

  timer_waveform i_timer_waveform (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_osc_input_one(timer_osc_input_one), .port_direction(port_direction),
    .osc_run(osc_run), .ext_clock_buffer_on(ext_clock_buffer_on),
    .compare_output_pin(compare_output_pin), .compare_output_oe(compare_output_oe),
    .pin_override(pin_override), .overflow_flag(overflow_flag), .compare_flag(compare_flag)
  );

  always #20 pclk = ~pclk;

  // Oscillator pin at a tenth of pclk, well inside the four-to-one limit
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    port_direction <= 1'($urandom_range(1, 0));
    if (osc_on) begin
      osc_cnt <= (osc_cnt == 3'h4) ? 3'h0 : osc_cnt + 3'h1;
      if (osc_cnt == 3'h4) begin
        timer_osc_input_one <= ~timer_osc_input_one;
      end
    end
    if (cycles == 60000) begin
      fails++;
      final_report();
    end
  end
  ////////////////////////////////////////
  function automatic logic [7:0] ctl(input logic [1:0] m, input logic [1:0] cm,
                                     input logic [2:0] cs);
    return {1'b0, m[0], cm, m[1], cs};
  endfunction : ctl

  function automatic int exp_high(input logic [1:0] m, input logic [1:0] cm, input int v);
    if (m == MODE_FAST) return cm[0] ? 255 - v : v + 1;
    return cm[0] ? 510 - 2 * v : 2 * v;
  endfunction : exp_high

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 8'h00);
    chk(r, x, "read data");
  endtask : rd

  task automatic wait_flag(input logic cf, input int lim, output int q);
    q = 0;
    @(posedge pclk);
    while ((cf ? compare_flag : overflow_flag) !== 1'b1 && q < lim) begin
      @(posedge pclk);
      q++;
    end
  endtask : wait_flag

  task automatic high_count(input int len, output int q);
    q = 0;
    repeat (len) begin
      @(posedge pclk);
      q += int'(compare_output_pin === 1'b1);
    end
  endtask : high_count
  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    timer_osc_input_one = 1'b0;
    port_direction = 1'b0;
    osc_on = 1'b0;
    osc_cnt = 3'h0;
    void'($urandom(24056));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) rd(12'(4 * i), 32'h0);
    apb(1'b1, 12'h010, 8'h55);
    chk(e, 1'b1, "unmapped write");
    rd(12'h010, 32'h0);
    chk(e, 1'b1, "unmapped read");
    repeat (3) begin
      c = 8'($urandom);
      apb(1'b1, ADDR_COMPARE, c);
      rd(ADDR_COMPARE, {24'h0, c});
      apb(1'b1, ADDR_COUNT, c);
      rd(ADDR_COUNT, {24'h0, c});
      apb(1'b1, ADDR_CONTROL, c & 8'hf8);
      rd(ADDR_CONTROL, {24'h0, c & 8'h78});
      apb(1'b1, ADDR_ASYNC, c & 8'hf7);
      rd(ADDR_ASYNC, {24'h0, c & 8'h10});
    end
    // divider taps; first tick phase is free, so a window
    for (int i = 1; i < 8; i++) begin
      apb(1'b1, ADDR_CONTROL, 8'h00);
      apb(1'b1, ADDR_COUNT, 8'hfe);
      apb(1'b1, ADDR_CONTROL, ctl(MODE_NORMAL, COM_OFF, 3'(i)));
      wait_flag(1'b0, 2100, p);
      chk(p + 3 >= div[i] && p <= 2 * div[i] + 8, 1'b1, "divided overflow");
    end
    apb(1'b1, ADDR_CONTROL, 8'h00);
    apb(1'b1, ADDR_COUNT, 8'hfe);
    wait_flag(1'b0, 300, p);
    chk(p, 300, "stopped timer");
    for (int j = 0; j < 4; j++) begin
      apb(1'b1, ADDR_CONTROL, 8'h00);
      apb(1'b1, ADDR_COMPARE, 8'h80);
      apb(1'b1, ADDR_CONTROL, ctl(2'(j), COM_OFF, 3'h1));
      wait_flag(1'b0, 600, p);
      wait_flag(1'b0, 600, p);
      chk(p, ovf_gap[j], "overflow spacing");
    end
    for (int k = 0; k < 12; k++) begin
      md = k < 6 ? MODE_FAST : MODE_PHASE;
      com = k % 2 ? COM_SET : COM_CLEAR;
      c = k < 2 ? 8'h00 : (k % 6) inside {2, 3} ? 8'hff : 8'($urandom_range(254, 1));
      apb(1'b1, ADDR_CONTROL, 8'h00);
      apb(1'b1, ADDR_COMPARE, c);
      apb(1'b1, ADDR_CONTROL, ctl(md, com, 3'h1));
      wait_flag(1'b0, 600, p);
      wait_flag(1'b0, 600, p);
      high_count(md == MODE_FAST ? 256 : 510, h);
      chk(h, exp_high(md, com, c), "pwm high time");
    end
    apb(1'b1, ADDR_CONTROL, 8'h00);
    apb(1'b1, ADDR_COMPARE, 8'h80);
    apb(1'b1, ADDR_CONTROL, ctl(MODE_FAST, COM_CLEAR, 3'h1));
    wait_flag(1'b0, 600, p);
    apb(1'b1, ADDR_COMPARE, 8'h40);
    wait_flag(1'b1, 300, p);
    chk(p > 100 && p < 140, 1'b1, "old compare kept");
    wait_flag(1'b1, 300, p);
    chk(p, 191, "new compare after top");
    c = 8'($urandom_range(120, 8));
    apb(1'b1, ADDR_CONTROL, 8'h00);
    apb(1'b1, ADDR_COMPARE, c);
    apb(1'b1, ADDR_COUNT, 8'h00);
    apb(1'b1, ADDR_CONTROL, ctl(MODE_CTC, COM_TOGGLE, 3'h1));
    for (int k = 0; k < 4; k++) begin
      e = compare_output_pin;
      wait_flag(1'b1, 300, p);
      if (k > 0) chk(p, c, "match spacing");
      if (k > 0) chk(compare_output_pin, !e, "toggle");
    end
    for (int k = 2; k < 4; k++) begin
      apb(1'b1, ADDR_CONTROL, ctl(MODE_CTC, 2'(k), 3'h1));
      wait_flag(1'b1, 300, p);
      wait_flag(1'b1, 300, p);
      chk(compare_output_pin, k == 3, "clear or set");
    end
    // count write hides the next match
    apb(1'b1, ADDR_CONTROL, ctl(MODE_CTC, COM_OFF, 3'h0));
    apb(1'b1, ADDR_COMPARE, 8'h40);
    apb(1'b1, ADDR_COUNT, 8'h40);
    apb(1'b1, ADDR_CONTROL, ctl(MODE_CTC, COM_OFF, 3'h1));
    wait_flag(1'b1, 400, p);
    chk(p > 200 && p < 300, 1'b1, "match after count write");
    // rewrite all three after the switch, control first
    osc_on <= 1'b1;
    apb(1'b1, ADDR_ASYNC, 8'h00);
    apb(1'b1, ADDR_ASYNC, 8'h08);
    for (int k = 0; k < 3; k++) begin
      c = k == 0 ? 8'h00 : 8'($urandom);
      apb(1'b1, 12'(4 * k), c);
      rd(ADDR_ASYNC, {24'h0, 8'h08 | busy[k]});
      n = 0;
      while (r[2:0] !== 3'h0 && n < 30) begin
        apb(1'b0, ADDR_ASYNC, 8'h00);
        n++;
      end
      chk(n >= 2 && n < 30, 1'b1, "busy duration");
      rd(12'(4 * k), {24'h0, c});
    end
    apb(1'b1, ADDR_ASYNC, 8'h00);
    apb(1'b1, ADDR_ASYNC, 8'h10);
    apb(1'b1, ADDR_ASYNC, 8'h18);
    apb(1'b1, ADDR_ASYNC, 8'h00);
    final_report();
  end
endmodule : timer_waveform_tb
`default_nettype wire
